/* File: testbench/hlerr_hub_model.sv */
// partner model: hub side that takes sci and smi message requests
`timescale 1ns/1ps
module hlerr_hub_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] ack_delay,
    input wire logic sci_req,
    input wire logic smi_req,
    output logic sci_ack,
    output logic smi_ack,
    output logic [7:0] sci_msgs,
    output logic [7:0] smi_msgs
);
    logic [3:0] sci_wait_ff;
    logic [3:0] smi_wait_ff;

    // each acknowledged request counts as one message taken off the link
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sci_ack <= 1'b0;
            sci_wait_ff <= 4'h0;
            sci_msgs <= 8'h00;
        end else if (sci_req && !sci_ack) begin
            if (sci_wait_ff >= ack_delay) begin
                sci_ack <= 1'b1;
                sci_wait_ff <= 4'h0;
                sci_msgs <= sci_msgs + 8'h01;
            end else begin
                sci_wait_ff <= sci_wait_ff + 4'h1;
            end
        end else begin
            sci_ack <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            smi_ack <= 1'b0;
            smi_wait_ff <= 4'h0;
            smi_msgs <= 8'h00;
        end else if (smi_req && !smi_ack) begin
            if (smi_wait_ff >= ack_delay) begin
                smi_ack <= 1'b1;
                smi_wait_ff <= 4'h0;
                smi_msgs <= smi_msgs + 8'h01;
            end else begin
                smi_wait_ff <= smi_wait_ff + 4'h1;
            end
        end else begin
            smi_ack <= 1'b0;
        end
    end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the hub link error message enable block
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic pwr_rst_n = 1'b0;
    logic [6:0] err_detect = 7'h00;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic sci_ack, smi_ack, sci_req, smi_req;
    logic [3:0] ack_delay = 4'h0;
    logic [7:0] sci_msgs, smi_msgs, sci_base, smi_base;
    int fails = 0;
    int checks = 0;

    always #12.5 clock = ~clock;

    hlerr_top hlerr_top_i (.CLOCK(clock), .RST_N(rst_n), .PWR_RST_N(pwr_rst_n),
        .ERR_DETECT(err_detect), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .SCI_ACK(sci_ack), .SMI_ACK(smi_ack), .SCI_REQ(sci_req),
        .SMI_REQ(smi_req));

    hlerr_hub_model hlerr_hub_model_i (.clock(clock), .rst_n(rst_n), .ack_delay(ack_delay),
        .sci_req(sci_req), .smi_req(smi_req), .sci_ack(sci_ack), .smi_ack(smi_ack),
        .sci_msgs(sci_msgs), .smi_msgs(smi_msgs));

    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check(rdata, exp, "read data");
    endtask

    // write then read back with no gap, as the bus allows
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check(rdata, exp, "read data");
    endtask

    task automatic pulse(input logic [6:0] v);
        @(posedge clock);
        err_detect <= v;
        @(posedge clock);
        err_detect <= 7'h00;
    endtask

    // waits until both requests have been taken, bounded
    task automatic settle();
        bit done;
        done = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        for (int n = 0; n < 40 && !done; n++) begin
            if (!sci_req && !smi_req) begin
                done = 1'b1;
            end else begin
                @(posedge clock);
                #1;
            end
        end
        if (!done) begin
            fails++;
            $display("[ERR] %0t message request never taken", $time);
            stop_test();
        end
    endtask

    task automatic mark();
        sci_base = sci_msgs;
        smi_base = smi_msgs;
    endtask

    task automatic msg_check(input logic [7:0] exp_sci, input logic [7:0] exp_smi);
        check(sci_msgs - sci_base, exp_sci, "sci messages");
        check(smi_msgs - smi_base, exp_smi, "smi messages");
    endtask

    task automatic clear_logs();
        wr_reg(8'h50, 8'h7f);
        wr_reg(8'h52, 8'h7f);
    endtask

    task automatic test_reset_values();
        rd_reg(8'h58, 8'h00);
        rd_reg(8'h5a, 8'h00);
        $display("test reset_values done");
    endtask

    task automatic test_reg_access();
        wr_reg(8'h58, 8'hff);
        wr_reg(8'h5a, 8'haa);
        rd_reg(8'h58, 8'h7f);
        rd_reg(8'h5a, 8'h2a);
        wr_reg(8'h59, 8'hff);
        rd_reg(8'h59, 8'h00);
        rd_reg(8'h58, 8'h7f);
        wr_rd(8'h58, 8'h95, 8'h15);
        wr_rd(8'h5a, 8'hc3, 8'h43);
        wr_reg(8'h58, 8'h00);
        wr_reg(8'h5a, 8'h00);
        $display("test reg_access done");
    endtask

    // per error bit: others enabled gives nothing, own bit enabled gives one message
    task automatic test_bits(input bit use_smi);
        logic [7:0] on, off, one;
        on = use_smi ? 8'h5a : 8'h58;
        off = use_smi ? 8'h58 : 8'h5a;
        for (int i = 0; i < 7; i++) begin
            one = 8'h01 << i;
            clear_logs();
            wr_reg(off, 8'h00);
            wr_reg(on, 8'h7f ^ one);
            mark();
            pulse(one[6:0]);
            settle();
            msg_check(8'h00, 8'h00);
            clear_logs();
            wr_reg(on, one);
            mark();
            pulse(one[6:0]);
            settle();
            msg_check(use_smi ? 8'h00 : 8'h01, use_smi ? 8'h01 : 8'h00);
        end
        wr_reg(on, 8'h00);
        $display("test bits done");
    endtask

    task automatic test_logs();
        clear_logs();
        wr_reg(8'h5a, 8'h00);
        wr_reg(8'h58, 8'h7f);
        mark();
        pulse(7'h24);
        settle();
        pulse(7'h01);
        settle();
        msg_check(8'h02, 8'h00);
        rd_reg(8'h50, 8'h04);
        rd_reg(8'h52, 8'h21);
        wr_reg(8'h52, 8'h01);
        rd_reg(8'h52, 8'h20);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_reg(8'h50, 8'h04);
        rd_reg(8'h52, 8'h20);
        rd_reg(8'h58, 8'h00);
        $display("test logs done");
    endtask

    task automatic test_mask();
        clear_logs();
        wr_reg(8'h54, 8'h08);
        wr_reg(8'h5a, 8'h7f);
        mark();
        pulse(7'h08);
        settle();
        msg_check(8'h00, 8'h00);
        rd_reg(8'h50, 8'h00);
        rd_reg(8'h52, 8'h00);
        rd_reg(8'h54, 8'h08);
        wr_reg(8'h54, 8'h00);
        $display("test mask done");
    endtask

    // slow hub: repeated events on a set flag add nothing
    task automatic test_once();
        ack_delay <= 4'h6;
        clear_logs();
        wr_reg(8'h58, 8'h00);
        wr_reg(8'h5a, 8'h7f);
        mark();
        pulse(7'h02);
        pulse(7'h02);
        settle();
        pulse(7'h02);
        settle();
        msg_check(8'h00, 8'h01);
        ack_delay <= 4'h0;
        $display("test once done");
    endtask

    // a new error and its clear in one cycle: the error stays logged
    task automatic test_set_wins();
        clear_logs();
        wr_reg(8'h58, 8'h00);
        wr_reg(8'h5a, 8'h00);
        pulse(7'h01);
        @(posedge clock);
        err_detect <= 7'h08;
        addr <= 8'h52;
        wdata <= 8'h08;
        wr <= 1'b1;
        @(posedge clock);
        err_detect <= 7'h00;
        wr <= 1'b0;
        rd_reg(8'h52, 8'h08);
        rd_reg(8'h50, 8'h01);
        $display("test set_wins done");
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        pwr_rst_n <= 1'b1;
        test_reset_values();
        test_reg_access();
        test_bits(1'b0);
        test_bits(1'b1);
        test_logs();
        test_mask();
        test_once();
        test_set_wins();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        $display("[ERR] %0t run did not finish", $time);
        stop_test();
    end
endmodule

/* File: verilog/hlerr_log.sv */
// sticky error log with write-one-to-clear bits
`timescale 1ns/1ps
module hlerr_log #(
    parameter int W = hlerr_pkg::ERR_W
) (
    input wire logic clock,
    input wire logic pwr_rst_n,
    input wire logic [W-1:0] set_vec,
    input wire logic [W-1:0] clr_vec,
    output logic [W-1:0] flags_ff,
    output logic [W-1:0] newly
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            // set wins over a clear in the same cycle
            always_ff @(posedge clock or negedge pwr_rst_n) begin
                if (!pwr_rst_n) begin
                    flags_ff[i] <= hlerr_pkg::LOG_RESET[i];
                end else begin
                    flags_ff[i] <= set_vec[i] | (flags_ff[i] & ~clr_vec[i]);
                end
            end
            assign newly[i] = set_vec[i] & ~flags_ff[i];
        end
    endgenerate
endmodule

/* File: verilog/hlerr_msg.sv */
// one message request toward the link, held until acknowledged
`timescale 1ns/1ps
module hlerr_msg (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic ack,
    output logic req
);
    hlerr_pkg::hlerr_msg_e state_ff;
    hlerr_pkg::hlerr_msg_e nxt_state;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            hlerr_pkg::MSG_IDLE: begin
                if (fire) begin
                    nxt_state = hlerr_pkg::MSG_WAIT;
                end
            end
            hlerr_pkg::MSG_WAIT: begin
                // a new event in the ack cycle keeps one more message pending
                if (ack && !fire) begin
                    nxt_state = hlerr_pkg::MSG_IDLE;
                end
            end
            default: begin
                nxt_state = hlerr_pkg::MSG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= hlerr_pkg::MSG_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign req = (state_ff == hlerr_pkg::MSG_WAIT);
endmodule

/* File: verilog/hlerr_pkg.sv */
// constants shared by the hub link error message enable block
package hlerr_pkg;
    localparam int ERR_W = 7;
    localparam int REG_W = 8;
    localparam int ADDR_W = 8;
    localparam int RESERVED_BIT = 7;

    localparam logic [ADDR_W-1:0] FIRST_LOG_ADDR = 8'h50;
    localparam logic [ADDR_W-1:0] NEXT_LOG_ADDR = 8'h52;
    localparam logic [ADDR_W-1:0] ERROR_MASK_ADDR = 8'h54;
    localparam logic [ADDR_W-1:0] SCI_ENABLE_ADDR = 8'h58;
    localparam logic [ADDR_W-1:0] SMI_ENABLE_ADDR = 8'h5a;

    localparam logic [REG_W-1:0] ENABLE_RESET = 8'h00;
    localparam logic [ERR_W-1:0] LOG_RESET = 7'h00;
    localparam logic [ERR_W-1:0] MASK_RESET = 7'h00;
    localparam logic [REG_W-1:0] RDATA_IDLE = 8'h00;

    typedef enum logic [1:0] {
        MSG_IDLE = 2'b00,
        MSG_WAIT = 2'b01
    } hlerr_msg_e;
endpackage

/* File: verilog/hlerr_top.sv */
// hub link error logging with per-error sci and smi message enables
`timescale 1ns/1ps
module hlerr_top (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic PWR_RST_N,
    input wire logic [hlerr_pkg::ERR_W-1:0] ERR_DETECT,
    input wire logic [hlerr_pkg::ADDR_W-1:0] ADDR,
    input wire logic [hlerr_pkg::REG_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [hlerr_pkg::REG_W-1:0] RDATA,
    input wire logic SCI_ACK,
    input wire logic SMI_ACK,
    output logic SCI_REQ,
    output logic SMI_REQ
);
    localparam int EW = hlerr_pkg::ERR_W;

    logic [EW-1:0] sci_en_ff;
    logic [EW-1:0] smi_en_ff;
    logic [EW-1:0] mask_ff;
    logic [EW-1:0] first_log_ff;
    logic [EW-1:0] next_log_ff;
    logic [EW-1:0] first_log_new;
    logic [EW-1:0] next_log_new;
    logic [EW-1:0] err_in;
    logic [EW-1:0] first_log_set;
    logic [EW-1:0] next_log_set;
    logic [EW-1:0] first_log_clr;
    logic [EW-1:0] next_log_clr;
    logic [EW-1:0] newly;
    logic [EW-1:0] sci_hit;
    logic [EW-1:0] smi_hit;
    logic [EW-1:0] wdata_low;
    logic sci_fire;
    logic smi_fire;
    logic wr_sci;
    logic wr_smi;
    logic wr_mask;
    logic [hlerr_pkg::REG_W-1:0] rdata_ff;
    logic [hlerr_pkg::REG_W-1:0] nxt_rdata;

    assign wdata_low = WDATA[EW-1:0];
    assign wr_sci = WR && (ADDR == hlerr_pkg::SCI_ENABLE_ADDR);
    assign wr_smi = WR && (ADDR == hlerr_pkg::SMI_ENABLE_ADDR);
    assign wr_mask = WR && (ADDR == hlerr_pkg::ERROR_MASK_ADDR);

    // enable registers; bit 7 is never stored
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sci_en_ff <= hlerr_pkg::ENABLE_RESET[EW-1:0];
        end else if (wr_sci) begin
            sci_en_ff <= wdata_low;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            smi_en_ff <= hlerr_pkg::ENABLE_RESET[EW-1:0];
        end else if (wr_smi) begin
            smi_en_ff <= wdata_low;
        end
    end

    // mask survives the functional reset
    always_ff @(posedge CLOCK or negedge PWR_RST_N) begin
        if (!PWR_RST_N) begin
            mask_ff <= hlerr_pkg::MASK_RESET;
        end else if (wr_mask) begin
            mask_ff <= wdata_low;
        end
    end

    assign err_in = ERR_DETECT & ~mask_ff;

    // first log takes the lowest error only while it is empty
    always_comb begin
        if (first_log_ff == '0) begin
            first_log_set = err_in & EW'(~err_in + EW'(1));
        end else begin
            first_log_set = '0;
        end
        next_log_set = err_in & ~first_log_set;
        first_log_clr = '0;
        next_log_clr = '0;
        if (WR && (ADDR == hlerr_pkg::FIRST_LOG_ADDR)) begin
            first_log_clr = wdata_low;
        end
        if (WR && (ADDR == hlerr_pkg::NEXT_LOG_ADDR)) begin
            next_log_clr = wdata_low;
        end
    end

    hlerr_log #(
        .W(EW)
    ) u_first_log (
        .clock(CLOCK),
        .pwr_rst_n(PWR_RST_N),
        .set_vec(first_log_set),
        .clr_vec(first_log_clr),
        .flags_ff(first_log_ff),
        .newly(first_log_new)
    );

    hlerr_log #(
        .W(EW)
    ) u_next_log (
        .clock(CLOCK),
        .pwr_rst_n(PWR_RST_N),
        .set_vec(next_log_set),
        .clr_vec(next_log_clr),
        .flags_ff(next_log_ff),
        .newly(next_log_new)
    );

    // only a rising flag counts, never a flag that stays set
    assign newly = first_log_new | next_log_new;

    genvar i;
    generate
        for (i = 0; i < EW; i = i + 1) begin : g_gate
            // per-flag gating for bits 6 down to 0
            assign sci_hit[i] = newly[i] & sci_en_ff[i];
            assign smi_hit[i] = newly[i] & smi_en_ff[i];
        end
    endgenerate

    // both may fire if software breaks the one-type convention
    assign sci_fire = |sci_hit;
    assign smi_fire = |smi_hit;

    hlerr_msg u_sci_msg (
        .clock(CLOCK),
        .rst_n(RST_N),
        .fire(sci_fire),
        .ack(SCI_ACK),
        .req(SCI_REQ)
    );

    hlerr_msg u_smi_msg (
        .clock(CLOCK),
        .rst_n(RST_N),
        .fire(smi_fire),
        .ack(SMI_ACK),
        .req(SMI_REQ)
    );

    // read data stand one cycle only, zero otherwise
    always_comb begin
        nxt_rdata = hlerr_pkg::RDATA_IDLE;
        if (RD) begin
            case (ADDR)
                hlerr_pkg::FIRST_LOG_ADDR: nxt_rdata = {1'b0, first_log_ff};
                hlerr_pkg::NEXT_LOG_ADDR: nxt_rdata = {1'b0, next_log_ff};
                hlerr_pkg::ERROR_MASK_ADDR: nxt_rdata = {1'b0, mask_ff};
                hlerr_pkg::SCI_ENABLE_ADDR: nxt_rdata = {1'b0, sci_en_ff};
                hlerr_pkg::SMI_ENABLE_ADDR: nxt_rdata = {1'b0, smi_en_ff};
                default: nxt_rdata = hlerr_pkg::RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_ff <= hlerr_pkg::RDATA_IDLE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;

    // checks

    AST_SCI_ISSUE: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        (|(newly & sci_en_ff)) |=> SCI_REQ
    ) else $error("sci request missing after enabled new flag");

    AST_SMI_ISSUE: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        (|(newly & smi_en_ff)) |=> SMI_REQ
    ) else $error("smi request missing after enabled new flag");

    AST_SCI_TA_BIT: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        (first_log_new[6] || next_log_new[6]) && sci_en_ff[6] |=> SCI_REQ
    ) else $error("target abort did not raise sci");

    AST_SCI_SUPPRESS: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        !SCI_REQ && ((newly & sci_en_ff) == '0) |=> !SCI_REQ
    ) else $error("sci raised without an enabled new flag");

    AST_SMI_SUPPRESS: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        !SMI_REQ && ((newly & smi_en_ff) == '0) |=> !SMI_REQ
    ) else $error("smi raised without an enabled new flag");

    AST_SMI_PARITY_BIT: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        !SMI_REQ && newly[0] && smi_en_ff[0] ##1 !SMI_ACK |=> SMI_REQ
    ) else $error("address parity error lost its smi");

    AST_SCI_READBACK: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        wr_sci ##1 (RD && ADDR == hlerr_pkg::SCI_ENABLE_ADDR && !WR)
        |=> RDATA == {1'b0, $past(wdata_low, 2)}
    ) else $error("sci enable readback wrong");

    AST_SMI_READBACK: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        wr_smi ##1 (RD && ADDR == hlerr_pkg::SMI_ENABLE_ADDR && !WR)
        |=> RDATA == {1'b0, $past(wdata_low, 2)}
    ) else $error("smi enable readback wrong");

    AST_RESERVED_ZERO: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        RD && (ADDR == hlerr_pkg::SCI_ENABLE_ADDR || ADDR == hlerr_pkg::SMI_ENABLE_ADDR)
        |=> RDATA[hlerr_pkg::RESERVED_BIT] == 1'b0
    ) else $error("reserved enable bit read as one");

    AST_NEXT_RECORD: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        (first_log_ff != '0) && (err_in != '0)
        |=> (next_log_ff & $past(err_in)) == $past(err_in)
    ) else $error("next log dropped a later error");

    AST_FIRST_SINGLE: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        $onehot0(first_log_ff)
    ) else $error("first log holds more than one flag");

    AST_MASK_BLOCKS: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        mask_ff[3] && !first_log_ff[3] && !next_log_ff[3]
        |=> !first_log_ff[3] && !next_log_ff[3]
    ) else $error("masked error was logged");

    AST_MASK_NO_MSG: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        (ERR_DETECT & ~mask_ff) == '0 |-> !sci_fire && !smi_fire
    ) else $error("masked error produced a message");

    AST_W1C_CLEAR: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        WR && ADDR == hlerr_pkg::NEXT_LOG_ADDR && err_in == '0
        |=> (next_log_ff & $past(wdata_low)) == '0
    ) else $error("write one did not clear next log flag");

    AST_SET_WINS: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        WR && ADDR == hlerr_pkg::NEXT_LOG_ADDR && (next_log_set & wdata_low) != '0
        |=> (next_log_ff & $past(next_log_set)) == $past(next_log_set)
    ) else $error("clear beat a new error");

    AST_ONCE_ONLY: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        SCI_REQ && SCI_ACK && !sci_fire ##1 (newly == '0)[*2] |-> !SCI_REQ
    ) else $error("sci repeated for a flag that stayed set");

    AST_REQ_HOLDS: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        SMI_REQ && !SMI_ACK |=> SMI_REQ
    ) else $error("smi request dropped before ack");

    AST_RDATA_ONE_CYCLE: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        !RD |=> RDATA == hlerr_pkg::RDATA_IDLE
    ) else $error("read data stood without a read");

    AST_SMI_TA_BIT: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        (first_log_new[6] || next_log_new[6]) && smi_en_ff[6] |=> SMI_REQ
    ) else $error("target abort did not raise smi");

    AST_SCI_PARITY_BIT: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        !SCI_REQ && newly[0] && sci_en_ff[0] ##1 !SCI_ACK |=> SCI_REQ
    ) else $error("address parity error lost its sci");

    AST_SCI_REQ_HOLDS: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        SCI_REQ && !SCI_ACK |=> SCI_REQ
    ) else $error("sci request dropped before ack");

    AST_SMI_ONCE_ONLY: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        SMI_REQ && SMI_ACK && !smi_fire ##1 (newly == '0)[*2] |-> !SMI_REQ
    ) else $error("smi repeated for a flag that stayed set");

    AST_SCI_EN_HOLD: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        !wr_sci |=> sci_en_ff == $past(sci_en_ff)
    ) else $error("sci enable changed without a write");

    AST_SMI_EN_HOLD: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        !wr_smi |=> smi_en_ff == $past(smi_en_ff)
    ) else $error("smi enable changed without a write");

    AST_SCI_RD_VALUE: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        RD && ADDR == hlerr_pkg::SCI_ENABLE_ADDR |=> RDATA == {1'b0, $past(sci_en_ff)}
    ) else $error("sci enable read data wrong");

    AST_SMI_RD_VALUE: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        RD && ADDR == hlerr_pkg::SMI_ENABLE_ADDR |=> RDATA == {1'b0, $past(smi_en_ff)}
    ) else $error("smi enable read data wrong");

    AST_FIRST_W1C: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        WR && ADDR == hlerr_pkg::FIRST_LOG_ADDR && err_in == '0
        |=> (first_log_ff & $past(wdata_low)) == '0
    ) else $error("write one did not clear first log flag");

    // logs must ride through the functional reset untouched
    AST_LOG_STICKY: assert property (
        @(posedge CLOCK) disable iff (!PWR_RST_N)
        !(WR && ADDR == hlerr_pkg::NEXT_LOG_ADDR)
        |=> (next_log_ff & $past(next_log_ff)) == $past(next_log_ff)
    ) else $error("next log flag lost without a clear");

    AST_FIRST_FROZEN: assert property (
        @(posedge CLOCK) disable iff (!RST_N || !PWR_RST_N)
        first_log_ff != '0 |=> (first_log_ff & ~$past(first_log_ff)) == '0
    ) else $error("first log took a second error");
endmodule
